// >>> hw/rsu_pkg.sv
// Shared types and constants of the rotate and shift datapath slice
package rsu_pkg;

  // ------------------------------------------------------------------
  // Widths
  // ------------------------------------------------------------------
  localparam int unsigned DATA_W = 32;
  localparam int unsigned WIDE_W = 64;
  localparam int unsigned WORD_W = 16;
  localparam int unsigned AMT_W  = 5;
  localparam int unsigned IMM_W  = 9;

  // ------------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------------
  localparam logic              CARRY_RESET  = 1'b0;
  localparam logic [DATA_W-1:0] RESULT_RESET = 32'h0000_0000;

  // ------------------------------------------------------------------
  // Operations and flag-write options
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    OP_WORD_ROTATE_INSERT,
    OP_ROTATE_RIGHT,
    OP_SHIFT_ARITH_LEFT,
    OP_SHIFT_ARITH_RIGHT
  } op_t;

  typedef enum logic [1:0] {
    FLAGS_NONE,
    WRITE_CARRY_OPTION,
    WRITE_ZERO_OPTION,
    WRITE_BOTH_FLAGS_OPTION
  } flag_opt_t;

  // ------------------------------------------------------------------
  // Request from the decoder and answer to the register file
  // ------------------------------------------------------------------
  typedef struct packed {
    op_t              op;
    logic [DATA_W-1:0] d;
    logic [DATA_W-1:0] s;
    logic             s_is_imm;
    logic [IMM_W-1:0] imm;
    logic             word_index;
    flag_opt_t        flags;
  } req_t;

  typedef struct packed {
    logic [DATA_W-1:0] value;
    logic              carry;
    logic              carry_we;
  } res_t;

endpackage

// >>> hw/funnel_shifter.sv
// 64-bit funnel shifter, right or (by bit reversal) left, with last bit out
`timescale 1ns/100ps
module funnel_shifter (
  input  wire logic [rsu_pkg::WIDE_W-1:0] data,
  input  wire logic [rsu_pkg::AMT_W-1:0]  amount,
  input  wire logic                       to_left,
  output logic      [rsu_pkg::WIDE_W-1:0] shifted,
  output logic                            last_out
);
  import rsu_pkg::*;

  logic [WIDE_W-1:0] reversed_in;
  logic [WIDE_W-1:0] source;
  logic [WIDE_W:0]   wide;
  logic [WIDE_W-1:0] right_result;
  logic [WIDE_W-1:0] reversed_out;

  // ------------------------------------------------------------------
  // Bit reversal turns a left shift into a right shift
  // ------------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < WIDE_W; i++) begin : g_rev
      assign reversed_in[i]  = data[WIDE_W-1-i];
      assign reversed_out[i] = right_result[WIDE_W-1-i];
    end
  endgenerate

  assign source = to_left ? reversed_in : data;

  // Extra low bit catches the last bit leaving the bottom
  assign wide         = {source, 1'b0} >> amount;
  assign right_result = wide[WIDE_W:1];
  assign last_out     = wide[0];
  assign shifted      = to_left ? reversed_out : right_result;

endmodule // funnel_shifter

// >>> hw/rotate_shift_unit.sv
// Rotate and shift datapath slice: word insert, rotate, arithmetic shifts
// How it works
// RQ1: Word insert puts the low half of D on top and word N of S below.
// RQ2: Rotate right turns D by S[4:0]; carry is the last bit out or D[0].
// RQ3: Shift left pads with D[0] and keeps the top word of the 64-bit value.
// RQ4: Shift-left carry is the last bit leaving the top, or D[31] at zero.
// RQ5: Shift right pads with D[31]; carry is the last bit out or D[0].
// RQ6: Each operation fits a two-clock slot and flags change only on request.
`timescale 1ns/100ps
module rotate_shift_unit (
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire logic          req_valid,
  input  wire rsu_pkg::req_t req,
  output logic               req_ready,
  output logic               res_valid,
  output rsu_pkg::res_t      res,
  output logic               carry_flag
);
  import rsu_pkg::*;

  // ------------------------------------------------------------------
  // Slot sequencing
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    SLOT_IDLE,
    SLOT_EXEC,
    SLOT_WRITE
  } slot_t;

  slot_t state;
  slot_t next_state;
  logic  take;

  assign req_ready = (state != SLOT_EXEC);
  assign take      = req_valid && req_ready;

  always_comb begin
    next_state = state;
    case (state)
      SLOT_IDLE:  next_state = take ? SLOT_EXEC : SLOT_IDLE;
      SLOT_EXEC:  next_state = SLOT_WRITE; // see RQ6
      SLOT_WRITE: next_state = take ? SLOT_EXEC : SLOT_IDLE;
      default:    next_state = SLOT_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= SLOT_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // ------------------------------------------------------------------
  // Operand capture
  // ------------------------------------------------------------------
  op_t               op;
  flag_opt_t         flags;
  logic [DATA_W-1:0] d;
  logic [DATA_W-1:0] s;
  logic              word_index;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      op         <= OP_WORD_ROTATE_INSERT;
      flags      <= FLAGS_NONE;
      d          <= RESULT_RESET;
      s          <= RESULT_RESET;
      word_index <= 1'b0;
    end else if (take) begin
      op         <= req.op;
      flags      <= req.flags;
      d          <= req.d;
      // Immediate source is zero-extended
      s          <= req.s_is_imm ? {{(DATA_W-IMM_W){1'b0}}, req.imm} : req.s;
      word_index <= req.word_index;
    end
  end

  // ------------------------------------------------------------------
  // Shift network
  // ------------------------------------------------------------------
  logic [AMT_W-1:0]  amount;
  logic              amount_zero;
  logic [WIDE_W-1:0] funnel_in;
  logic [WIDE_W-1:0] funnel_out;
  logic              funnel_last;
  logic              to_left;

  assign amount      = s[AMT_W-1:0];
  assign amount_zero = (amount == '0);
  assign to_left     = (op == OP_SHIFT_ARITH_LEFT);

  always_comb begin
    case (op)
      OP_ROTATE_RIGHT:      funnel_in = {d, d};
      OP_SHIFT_ARITH_LEFT:  funnel_in = {d, {DATA_W{d[0]}}}; // see RQ3
      OP_SHIFT_ARITH_RIGHT: funnel_in = {{DATA_W{d[DATA_W-1]}}, d}; // see RQ5
      default:              funnel_in = {d, d};
    endcase
  end

  funnel_shifter u_funnel (
    .data     (funnel_in),
    .amount   (amount),
    .to_left  (to_left),
    .shifted  (funnel_out),
    .last_out (funnel_last)
  );

  // ------------------------------------------------------------------
  // Result and carry selection
  // ------------------------------------------------------------------
  logic [DATA_W-1:0] next_value;
  logic              next_carry;
  logic              carry_selected;

  always_comb begin
    next_value = RESULT_RESET;
    next_carry = 1'b0;
    case (op)
      OP_WORD_ROTATE_INSERT: begin
        next_value = {d[WORD_W-1:0],
                      word_index ? s[DATA_W-1:WORD_W]
                                 : s[WORD_W-1:0]}; // see RQ1
        next_carry = 1'b0;
      end
      OP_ROTATE_RIGHT: begin
        next_value = funnel_out[DATA_W-1:0]; // see RQ2
        next_carry = amount_zero ? d[0] : funnel_last; // see RQ2
      end
      OP_SHIFT_ARITH_LEFT: begin
        next_value = funnel_out[WIDE_W-1:DATA_W]; // see RQ3
        next_carry = amount_zero ? d[DATA_W-1] : funnel_last; // see RQ4
      end
      OP_SHIFT_ARITH_RIGHT: begin
        next_value = funnel_out[DATA_W-1:0]; // see RQ5
        next_carry = amount_zero ? d[0] : funnel_last; // see RQ5
      end
      default: begin
        next_value = RESULT_RESET;
        next_carry = 1'b0;
      end
    endcase
  end

  // Word insert never writes flags; zero option alone leaves carry
  assign carry_selected = (op != OP_WORD_ROTATE_INSERT) &&
                          ((flags == WRITE_CARRY_OPTION) ||
                           (flags == WRITE_BOTH_FLAGS_OPTION)); // see RQ6

  // ------------------------------------------------------------------
  // Answer registers
  // ------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      res_valid <= 1'b0;
    end else begin
      res_valid <= (state == SLOT_EXEC); // see RQ6
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      res.value    <= RESULT_RESET;
      res.carry    <= CARRY_RESET;
      res.carry_we <= 1'b0;
    end else if (state == SLOT_EXEC) begin
      res.value    <= next_value;
      res.carry    <= next_carry;
      res.carry_we <= carry_selected;
    end else begin
      res.carry_we <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // Held carry flag
  // ------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      carry_flag <= CARRY_RESET;
    end else if (state == SLOT_EXEC && carry_selected) begin
      carry_flag <= next_carry; // see RQ6
    end
  end

endmodule // rotate_shift_unit

// >>> verif/rsu_properties.sv
// Concurrent checks of the rotate and shift slice
`timescale 1ns/100ps
module rsu_properties
  import rsu_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic req_valid,
  input wire req_t req,
  input wire logic req_ready,
  input wire logic res_valid,
  input wire res_t res,
  input wire logic carry_flag
);
  req_t        q;
  logic [31:0] d, s;
  logic [4:0]  n;
  logic [63:0] rr, sl, sr;
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n) q <= '0;
    else if (req_valid && req_ready) q <= req;
  assign d = q.d;
  assign s = q.s_is_imm ? {23'h0, q.imm} : q.s;
  assign n = s[4:0];
  assign rr = {d, d} >> n;
  assign sl = {d, {32{d[0]}}} << n;
  assign sr = {{32{d[31]}}, d} >> n;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  slot_timing_a: assert property (
    req_valid && req_ready |=> !req_ready ##1 res_valid)
    else $error("answer not in slot");
  word_insert_a: assert property (
    res_valid && q.op == OP_WORD_ROTATE_INSERT |-> !res.carry_we &&
    res.value == {d[15:0], q.word_index ? s[31:16] : s[15:0]})
    else $error("word insert wrong");
  rotate_value_a: assert property (
    res_valid && q.op == OP_ROTATE_RIGHT |-> res.value == rr[31:0]
    && res.carry == (n != 0 ? d[n-1] : d[0]))
    else $error("rotate wrong");
  left_value_a: assert property (
    res_valid && q.op == OP_SHIFT_ARITH_LEFT |-> res.value == sl[63:32])
    else $error("left shift wrong");
  left_carry_a: assert property (
    res_valid && q.op == OP_SHIFT_ARITH_LEFT |->
    res.carry == (n != 0 ? d[32-n] : d[31]))
    else $error("left carry wrong");
  right_shift_a: assert property (
    res_valid && q.op == OP_SHIFT_ARITH_RIGHT |-> res.value == sr[31:0]
    && res.carry == (n != 0 ? d[n-1] : d[0]))
    else $error("right shift wrong");
  flag_option_a: assert property (
    res_valid |-> res.carry_we == (q.op != OP_WORD_ROTATE_INSERT &&
    q.flags inside {WRITE_CARRY_OPTION, WRITE_BOTH_FLAGS_OPTION}))
    else $error("carry write wrong");
  flag_hold_a: assert property (
    $changed(carry_flag) |-> res_valid && res.carry_we
    && carry_flag == res.carry)
    else $error("carry flag moved");
  cover property (res_valid && res.carry_we);
  cover property (res_valid && q.op == OP_SHIFT_ARITH_LEFT);
  cover property (req_valid && !req_ready);
endmodule // rsu_properties

bind rotate_shift_unit rsu_properties chk (.clk, .rst_n, .req_valid,
  .req, .req_ready, .res_valid, .res, .carry_flag);

// >>> verif/decoder_model.sv
// Instruction decoder model that offers requests
`timescale 1ns/100ps
module decoder_model
  import rsu_pkg::*;
(
  input  wire logic clk,
  input  wire logic req_ready,
  output req_t      req,
  output logic      req_valid
);
  initial begin
    req_valid = 1'h0;
    req = '0;
  end
  task automatic send(input req_t r);
    logic rdy;
    req <= r;
    req_valid <= 1'h1;
    // Ready read once settled, then the edge that judges it
    do begin
      #1;
      rdy = req_ready;
      @(posedge clk);
    end while (rdy !== 1'h1);
  endtask
  // Released operands show garbage
  task automatic idle();
    req_valid <= 1'h0;
    req <= ~req;
  endtask
endmodule // decoder_model

// >>> verif/rotate_shift_unit_tb.sv
// Self-checking bench of the rotate and shift slice
`timescale 1ns/100ps
`define CHK(n, e, g) \
  checked++; \
  if ((g) !== (e)) begin \
    fail_count++; \
    $display("CHECK FAILED %s exp %h got %h", n, e, g); \
  end
module rotate_shift_unit_tb;
  import rsu_pkg::*;
  logic clk, rst_n, req_valid, req_ready, res_valid, carry_flag;
  req_t req;
  res_t res;
  int   fail_count = 0;
  int   checked = 0;
  rotate_shift_unit dut (.clk, .rst_n, .req_valid, .req, .req_ready,
    .res_valid, .res, .carry_flag);
  decoder_model src (.clk, .req_ready, .req, .req_valid);
  initial begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end
  function automatic req_t mk(op_t o, logic [31:0] d, s, logic i, w,
                              flag_opt_t f);
    return '{o, d, i ? ~s : s, i, s[8:0], w, f};
  endfunction
  task automatic do_op(input req_t r, input logic [31:0] v,
                       input logic c, we);
    logic cf;
    @(posedge clk);
    cf = carry_flag;
    src.send(r);
    src.idle();
    @(posedge clk);
    #1;
    `CHK("res_valid", 1'h1, res_valid)
    `CHK("value", v, res.value)
    `CHK("carry_we", we, res.carry_we)
    `CHK("carry_flag", we ? c : cf, carry_flag)
  endtask
  task automatic t_insert();
    do_op(mk(OP_WORD_ROTATE_INSERT, 32'h5678_9abc, 32'h5678_9abc, 1'h0,
      1'h1, WRITE_CARRY_OPTION), 32'h9abc_5678, 1'h0, 1'h0);
    do_op(mk(OP_WORD_ROTATE_INSERT, 32'h1234_abcd, 32'h1ff, 1'h1, 1'h0,
      WRITE_BOTH_FLAGS_OPTION), 32'habcd_01ff, 1'h0, 1'h0);
  endtask
  task automatic t_rotate();
    do_op(mk(OP_ROTATE_RIGHT, 32'h8000_0001, 32'h1, 1'h0, 1'h0,
      WRITE_CARRY_OPTION), 32'hc000_0000, 1'h1, 1'h1);
    do_op(mk(OP_ROTATE_RIGHT, 32'h2, 32'h1f, 1'h1, 1'h0,
      WRITE_BOTH_FLAGS_OPTION), 32'h4, 1'h0, 1'h1);
    do_op(mk(OP_ROTATE_RIGHT, 32'h3, 32'hffff_ffe0, 1'h0, 1'h0,
      WRITE_CARRY_OPTION), 32'h3, 1'h1, 1'h1);
  endtask
  task automatic t_left();
    do_op(mk(OP_SHIFT_ARITH_LEFT, 32'hc000_0001, 32'h2, 1'h0, 1'h0,
      FLAGS_NONE), 32'h7, 1'h1, 1'h0);
    do_op(mk(OP_SHIFT_ARITH_LEFT, 32'h4000_0000, 32'h0, 1'h1, 1'h0,
      WRITE_CARRY_OPTION), 32'h4000_0000, 1'h0, 1'h1);
    do_op(mk(OP_SHIFT_ARITH_LEFT, 32'hc000_0001, 32'h2, 1'h1, 1'h0,
      WRITE_ZERO_OPTION), 32'h7, 1'h1, 1'h0);
  endtask
  task automatic t_right();
    do_op(mk(OP_SHIFT_ARITH_RIGHT, 32'h8000_0003, 32'h1, 1'h0, 1'h0,
      WRITE_CARRY_OPTION), 32'hc000_0001, 1'h1, 1'h1);
    do_op(mk(OP_SHIFT_ARITH_RIGHT, 32'h8000_0000, 32'h1f, 1'h1, 1'h0,
      WRITE_BOTH_FLAGS_OPTION), 32'hffff_ffff, 1'h0, 1'h1);
  endtask
  task automatic t_back_to_back();
    @(posedge clk);
    src.send(mk(OP_ROTATE_RIGHT, 32'h8, 32'h4, 1'h1, 1'h0,
      WRITE_CARRY_OPTION));
    src.send(mk(OP_SHIFT_ARITH_RIGHT, 32'hffff_fff0, 32'h4, 1'h0, 1'h0,
      FLAGS_NONE));
    `CHK("first", 32'h8000_0000, res.value)
    `CHK("first flag", 1'h1, carry_flag)
    src.idle();
    @(posedge clk);
    #1;
    `CHK("second", 32'hffff_ffff, res.value)
    `CHK("flag", 1'h1, carry_flag)
  endtask
  task automatic results();
    if (fail_count == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge clk);
    fail_count++;
    results();
  end
  initial begin
    rst_n = 1'h0;
    repeat (6) @(posedge clk);
    rst_n <= 1'h1;
    t_insert();
    t_rotate();
    t_left();
    t_right();
    t_back_to_back();
    results();
  end
endmodule // rotate_shift_unit_tb
